// *** hdtc_pkg.sv ***
/*
  constants and types for the transmit length counter and protocol test control.
  assumes an 8-bit register port and a byte-wide fifo path on ref_clk.
*/
`default_nettype none
package hdtc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_TXCNT = 8'h19;
  localparam logic [7:0] OFS_TEST = 8'h1A;
  localparam logic [7:0] OFS_CFG = 8'h1E;
  localparam logic [7:0] OFS_STAT = 8'h1F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // test control bit positions
  localparam int TB_SRST = 7;
  localparam int TB_RX_TO_TX_LOOPBACK = 6;
  localparam int TB_CRC = 3;
  localparam int TB_FIFO = 2;
  localparam int TB_ADDR = 1;
  localparam int TB_TRLOOP = 0;
  localparam logic [7:0] TEST_WMASK = 8'h4F;
  // config bit positions
  localparam int CB_CYCLE = 0;
  localparam int CB_RECEIVER_ENABLE_BIT = 1;
  localparam int CB_TRANSMITTER_ENABLE_BIT = 2;
  localparam int CB_FLIP = 3;
  localparam int CB_IDX = 4;
  // ****************************************
  // serial comparator tests
  // ****************************************
  localparam logic [15:0] CRC_REMAINDER = 16'hF0B8;
  localparam logic [4:0] SER_LEN = 5'h10;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [1:0] TAG_EOP = 2'h1;
  localparam logic [1:0] TAG_NONE = 2'h0;
  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_DONE} hdtc_ser_t;
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] tag;
  } hdtc_byte_t;
endpackage : hdtc_pkg
`default_nettype wire

// *** hdtc_core.sv ***
/*
  transmit length counter, protocol test control, two-entry byte buffers.
  assumes fifos, receiver and transmitter on ref_clk; serial test clock and
  data and the line bit arrive from pins.
*/
// Implementation choice: the plain strobed port.
// Behaviour
// - 8-bit counter loaded by software with the next packet length.
// - when the counter is one the next fifo write is tagged end of packet.
// - counter decrements once per software write on the transmit port, as it completes, and holds at zero.
// - with cycle set the programmed length reloads after each packet.
// - soft reset bit holds the logic in reset but itself stays set.
// - soft reset clears only after two zero writes, or hardware reset.
// - rx-to-tx loopback copies received bytes and tags into both fifos.
// - looped packets, good or bad, are sent as if written by software.
// - crc test shifts 16 receive clocks into the comparator then stops.
// - crc test compares against F0B8, any bit may be corrupted.
// - fifo test turns tx writes into rx writes, rx reads into tx reads.
// - fifo test routes write tags to rx fifo, tx fifo tag to status.
// - address test shifts 16 receive clocks into the address comparator then stops.
// - tx-to-rx loopback feeds the transmit bit stream to the receiver.
`timescale 1ns/10ps
`default_nettype none
module hdtc_buf #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic in_ready_nxt,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rp_q];
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    if (pop) rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
    in_ready_nxt = (cnt_d != CW'(DEPTH));
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      in_ready <= in_ready_nxt;
      out_valid <= (cnt_d != '0);
    end
  end
  always_ff @(posedge clk) begin
    if (push && !flush) mem_q[wp_q] <= in_data;
  end
endmodule : hdtc_buf

module hdtc_core
  import hdtc_pkg::*;
#(
  parameter logic [15:0] TEST_ADDR = 16'h0000,
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cpu_txw_valid,
  input wire logic [7:0] cpu_txw_data,
  output logic cpu_txw_ready,
  input wire logic rx_byte_valid,
  input wire hdtc_byte_t rx_byte,
  output logic rx_byte_ready,
  output logic txf_valid,
  output hdtc_byte_t txf_word,
  input wire logic txf_ready,
  output logic rxf_valid,
  output hdtc_byte_t rxf_word,
  input wire logic rxf_ready,
  input wire logic cpu_rxf_rd,
  output logic rxf_rd,
  output logic txf_rd,
  input wire logic [1:0] rxf_out_tag,
  input wire logic [1:0] txf_out_tag,
  output logic [1:0] rx_tag_status,
  input wire logic receive_bit_clock,
  input wire logic test_sdi,
  input wire logic line_rx_bit,
  input wire logic tx_serial_bit,
  output logic rx_serial_in,
  output logic [1:0] test_clk_run,
  output logic [1:0] test_match,
  output logic protocol_soft_reset,
  output logic receiver_enable_bit,
  output logic transmitter_enable_bit
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] cnt_q, cnt_d, len_q, len_d, test_q, test_d, cfg_q, cfg_d;
  logic [7:0] rdata_d;
  logic zc_q, zc_d, soft_d;
  logic cpu_take, rx_take, tx_push, rx_push, load_wr, test_wr;
  logic fifo_test, rx_to_tx_loopback;
  hdtc_byte_t cpu_word, tx_in, rx_in;
  logic [1:0] run_q, match_q;
  logic [4:0] bits_q [2];
  assign fifo_test = test_q[TB_FIFO];
  assign rx_to_tx_loopback = test_q[TB_RX_TO_TX_LOOPBACK];
  assign load_wr = reg_wr && hit(reg_addr, OFS_TXCNT);
  assign test_wr = reg_wr && hit(reg_addr, OFS_TEST);
  assign cpu_take = cpu_txw_valid && cpu_txw_ready;
  assign rx_take = rx_byte_valid && rx_byte_ready;
  assign cpu_word = '{data: cpu_txw_data, tag: (cnt_q == CNT_ONE) ? TAG_EOP : TAG_NONE};
  assign tx_in = rx_to_tx_loopback ? rx_byte : cpu_word;
  assign tx_push = (rx_to_tx_loopback && rx_take) || (!fifo_test && cpu_take);
  assign rx_in = fifo_test ? cpu_word : rx_byte;
  assign rx_push = fifo_test ? cpu_take : rx_take;
  always_comb begin
    cnt_d = cnt_q;
    len_d = len_q;
    test_d = test_q;
    cfg_d = cfg_q;
    zc_d = zc_q;
    soft_d = test_q[TB_SRST];
    if (cpu_take) begin
      if (cnt_q == CNT_ONE && cfg_q[CB_CYCLE]) cnt_d = len_q;
      else if (cnt_q != '0) cnt_d = cnt_q - CNT_ONE;
    end
    if (load_wr) begin
      cnt_d = reg_wdata;
      len_d = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, OFS_CFG)) cfg_d = reg_wdata;
    if (test_wr) begin
      if (reg_wdata[TB_SRST]) begin
        soft_d = 1'b1;
        zc_d = 1'b0;
      end else if (test_q[TB_SRST]) begin
        soft_d = !zc_q;
        zc_d = !zc_q;
      end
      test_d = reg_wdata & TEST_WMASK;
      test_d[TB_SRST] = soft_d;
    end
    if (soft_d) begin
      cnt_d = RST_BYTE;
      len_d = RST_BYTE;
      cfg_d = RST_BYTE;
      test_d = RST_BYTE;
      test_d[TB_SRST] = 1'b1;
    end
    rdata_d = RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        OFS_TXCNT: rdata_d = cnt_q;
        OFS_TEST: rdata_d = test_q;
        OFS_CFG: rdata_d = cfg_q;
        OFS_STAT: rdata_d = {4'h0, run_q, match_q};
        default: rdata_d = RST_BYTE;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= RST_BYTE;
      len_q <= RST_BYTE;
      test_q <= RST_BYTE;
      cfg_q <= RST_BYTE;
      zc_q <= 1'b0;
      reg_rdata <= RST_BYTE;
    end else begin
      cnt_q <= cnt_d;
      len_q <= len_d;
      test_q <= test_d;
      cfg_q <= cfg_d;
      zc_q <= zc_d;
      reg_rdata <= rdata_d;
    end
  end
  assign protocol_soft_reset = test_q[TB_SRST];
  assign receiver_enable_bit = cfg_q[CB_RECEIVER_ENABLE_BIT];
  assign transmitter_enable_bit = cfg_q[CB_TRANSMITTER_ENABLE_BIT];
  // ****************************************
  // byte paths
  // ****************************************
  // flush in the very cycle soft reset is set, so no stored word leaks out after it
  logic tx_nxt, rx_nxt, cpu_rdy_d, rxb_rdy_d;
  hdtc_buf #(.W($bits(hdtc_byte_t)), .DEPTH(BUF_DEPTH)) u_txb (
    .clk(ref_clk), .rst_n(rst_n), .flush(soft_d),
    .in_valid(tx_push), .in_data(tx_in), .in_ready(), .in_ready_nxt(tx_nxt),
    .out_valid(txf_valid), .out_data(txf_word), .out_ready(txf_ready));
  hdtc_buf #(.W($bits(hdtc_byte_t)), .DEPTH(BUF_DEPTH)) u_rxb (
    .clk(ref_clk), .rst_n(rst_n), .flush(soft_d),
    .in_valid(rx_push), .in_data(rx_in), .in_ready(), .in_ready_nxt(rx_nxt),
    .out_valid(rxf_valid), .out_data(rxf_word), .out_ready(rxf_ready));
  assign cpu_rdy_d = !soft_d && (test_d[TB_FIFO] ? rx_nxt : (tx_nxt && !test_d[TB_RX_TO_TX_LOOPBACK]));
  assign rxb_rdy_d = !soft_d && !test_d[TB_FIFO] && rx_nxt && (tx_nxt || !test_d[TB_RX_TO_TX_LOOPBACK]);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_txw_ready <= 1'b0;
      rx_byte_ready <= 1'b0;
      rxf_rd <= 1'b0;
      txf_rd <= 1'b0;
      rx_tag_status <= TAG_NONE;
    end else begin
      cpu_txw_ready <= cpu_rdy_d;
      rx_byte_ready <= rxb_rdy_d;
      rxf_rd <= cpu_rxf_rd && !fifo_test;
      txf_rd <= cpu_rxf_rd && fifo_test;
      rx_tag_status <= fifo_test ? txf_out_tag : rxf_out_tag;
    end
  end
  // ****************************************
  // pin synchronisers and serial tests
  // ****************************************
  logic [2:0] s1_q, s2_q;
  logic rxc_d3_q, rxc_rise;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      rxc_d3_q <= 1'b0;
      rx_serial_in <= 1'b0;
    end else begin
      s1_q <= {line_rx_bit, test_sdi, receive_bit_clock};
      s2_q <= s1_q;
      rxc_d3_q <= s2_q[0];
      rx_serial_in <= test_q[TB_TRLOOP] ? tx_serial_bit : s2_q[2];
    end
  end
  assign rxc_rise = s2_q[0] && !rxc_d3_q;
  hdtc_ser_t st_q [2];
  logic [15:0] sh_q [2];
  logic [15:0] flip;
  assign flip = cfg_q[CB_FLIP] ? (16'h0001 << cfg_q[7:CB_IDX]) : 16'h0000;
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_ser
    hdtc_ser_t st_d;
    logic [15:0] sh_d, ref_v;
    logic [4:0] bits_d;
    logic en;
    assign en = test_q[(gi == 0) ? TB_CRC : TB_ADDR];
    assign ref_v = (gi == 0) ? (CRC_REMAINDER ^ flip) : TEST_ADDR;
    always_comb begin
      st_d = st_q[gi];
      sh_d = sh_q[gi];
      bits_d = bits_q[gi];
      case (st_q[gi])
        SER_IDLE: begin
          sh_d = '0;
          bits_d = '0;
          if (en) st_d = SER_SHIFT;
        end
        SER_SHIFT: begin
          if (rxc_rise) begin
            sh_d = {sh_q[gi][14:0], s2_q[1]};
            bits_d = bits_q[gi] + 5'h01;
            if (bits_d == SER_LEN) st_d = SER_DONE;
          end
        end
        SER_DONE: st_d = SER_DONE;
        default: st_d = SER_IDLE;
      endcase
      if (!en) st_d = SER_IDLE;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        st_q[gi] <= SER_IDLE;
        sh_q[gi] <= '0;
        bits_q[gi] <= '0;
        run_q[gi] <= 1'b0;
        match_q[gi] <= 1'b0;
      end else begin
        st_q[gi] <= st_d;
        sh_q[gi] <= sh_d;
        bits_q[gi] <= bits_d;
        run_q[gi] <= (st_d == SER_SHIFT);
        match_q[gi] <= (st_d == SER_DONE) && (sh_d == ref_v);
      end
    end
  end
  assign test_clk_run = run_q;
  assign test_match = match_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_eop_tag_one: assert property (cpu_take && !rx_to_tx_loopback |-> (fifo_test ? rx_in.tag : tx_in.tag) == ((cnt_q == CNT_ONE) ? TAG_EOP : TAG_NONE)) else $error("eop tag wrong");
  a_count_decrement: assert property (cpu_take && cnt_q > CNT_ONE && !load_wr && !soft_d |=> cnt_q == $past(cnt_q) - CNT_ONE) else $error("no decrement");
  a_cycle_reload: assert property (cpu_take && cnt_q == CNT_ONE && cfg_q[CB_CYCLE] && !load_wr && !soft_d |=> cnt_q == len_q) else $error("no reload");
  a_soft_holds: assert property (protocol_soft_reset |-> cnt_q == '0 && !txf_valid && !cpu_txw_ready) else $error("soft reset leak");
  a_soft_two_zero: assert property (test_wr && !reg_wdata[TB_SRST] && protocol_soft_reset |=> protocol_soft_reset == !$past(zc_q)) else $error("soft clear order");
  a_rt_copy: assert property (rx_take && rx_to_tx_loopback |-> tx_push && tx_in == rx_byte && rx_push) else $error("loop copy missing");
  a_fifo_redirect: assert property (cpu_take && fifo_test |-> rx_push && !tx_push && rx_in.data == cpu_txw_data) else $error("redirect failed");
  a_tag_status: assert property (fifo_test |=> rx_tag_status == $past(txf_out_tag)) else $error("tag status wrong");
  a_shift_len: assert property ($fell(run_q[0]) && test_q[TB_CRC] |-> bits_q[0] == SER_LEN) else $error("crc shift length");
  a_addr_len: assert property ($fell(run_q[1]) && test_q[TB_ADDR] |-> bits_q[1] == SER_LEN) else $error("addr shift length");
  a_tr_loop: assert property (test_q[TB_TRLOOP] |=> rx_serial_in == $past(tx_serial_bit)) else $error("tr loop wrong");
  c_cycle_reload: cover property (cpu_take && cnt_q == CNT_ONE && cfg_q[CB_CYCLE]);
  c_soft_clear: cover property ($fell(protocol_soft_reset));
  c_crc_match: cover property ($rose(match_q[0]));
  c_redirect: cover property (cpu_take && fifo_test);
endmodule : hdtc_core
`default_nettype wire

// *** hdtc_core_tb.sv ***
/*
  self-checking bench for hdtc_core: registers, length counter, buffers, test modes.
  assumes the hdtc_pkg constants, a 20 MHz ref_clk and the design's own assertions.
*/
`timescale 1ns/10ps
`default_nettype none
module hdtc_core_tb;
  import hdtc_pkg::*;
  // ****************************************
  // signals and design
  // ****************************************
  localparam logic [15:0] ADDR_REF = 16'h5A3C;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} hdtc_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] cpu_txw_data = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] rv;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_txw_valid = 1'b0, rx_byte_valid = 1'b0;
  logic txf_ready = 1'b1, rxf_ready = 1'b1, cpu_rxf_rd = 1'b0, receive_bit_clock = 1'b0;
  logic test_sdi = 1'b0, line_rx_bit = 1'b1, tx_serial_bit = 1'b0;
  logic [1:0] rxf_out_tag = 2'b01;
  logic [1:0] txf_out_tag = 2'b10;
  hdtc_byte_t rx_byte = '0;
  hdtc_byte_t txf_word, rxf_word;
  hdtc_byte_t txq[$], rxq[$];
  logic cpu_txw_ready, rx_byte_ready, txf_valid, rxf_valid, rxf_rd, txf_rd, rx_serial_in;
  logic protocol_soft_reset, receiver_enable_bit, transmitter_enable_bit;
  logic [1:0] rx_tag_status, test_clk_run, test_match;
  int n_errors = 0;
  int samples_checked = 0;
  hdtc_row_t rows[6] = '{'{8'h19, 8'h5A, 8'h5A}, '{8'h1A, 8'h3E, 8'h0E}, '{8'h1A, 8'h00, 8'h00},
    '{8'h1E, 8'h06, 8'h06}, '{8'h1E, 8'h00, 8'h00}, '{8'h20, 8'hFF, 8'h00}};

  hdtc_core #(.TEST_ADDR(ADDR_REF), .BUF_DEPTH(2)) i_hdtc_core (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_txw_valid(cpu_txw_valid),
    .cpu_txw_data(cpu_txw_data), .cpu_txw_ready(cpu_txw_ready), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_byte_ready(rx_byte_ready), .txf_valid(txf_valid),
    .txf_word(txf_word), .txf_ready(txf_ready), .rxf_valid(rxf_valid), .rxf_word(rxf_word),
    .rxf_ready(rxf_ready), .cpu_rxf_rd(cpu_rxf_rd), .rxf_rd(rxf_rd), .txf_rd(txf_rd),
    .rxf_out_tag(rxf_out_tag), .txf_out_tag(txf_out_tag), .rx_tag_status(rx_tag_status),
    .receive_bit_clock(receive_bit_clock), .test_sdi(test_sdi), .line_rx_bit(line_rx_bit),
    .tx_serial_bit(tx_serial_bit), .rx_serial_in(rx_serial_in), .test_clk_run(test_clk_run),
    .test_match(test_match), .protocol_soft_reset(protocol_soft_reset),
    .receiver_enable_bit(receiver_enable_bit), .transmitter_enable_bit(transmitter_enable_bit));

  always #25 ref_clk = ~ref_clk;

  // words leaving the buffers, taken as the fifo sees them
  always @(posedge ref_clk) begin
    if (txf_valid && txf_ready) txq.push_back(txf_word);
    if (rxf_valid && rxf_ready) rxq.push_back(rxf_word);
  end

  // ****************************************
  // tasks
  // ****************************************
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // ready is registered, so its value at the falling edge decides the next take
  task push(input logic to_rx, input hdtc_byte_t w);
    int k;
    k = 0;
    @(posedge ref_clk);
    if (to_rx) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= w;
    end else begin
      cpu_txw_valid <= 1'b1;
      cpu_txw_data <= w.data;
    end
    do begin
      @(negedge ref_clk);
      k++;
    end while ((to_rx ? rx_byte_ready : cpu_txw_ready) !== 1'b1 && k < 50);
    if (k >= 50) chk("push taken", 16'h0000, 16'h0001);
    @(posedge ref_clk);
    rx_byte_valid <= 1'b0;
    cpu_txw_valid <= 1'b0;
  endtask : push

  task pop(input logic from_rx, input hdtc_byte_t e);
    hdtc_byte_t w;
    w = 'x;
    if (from_rx && rxq.size() > 0) w = rxq.pop_front();
    else if (!from_rx && txq.size() > 0) w = txq.pop_front();
    chk(from_rx ? "rx word" : "tx word", 16'(w), 16'(e));
  endtask : pop

  task rpulse(input logic [1:0] e_rd, input logic [1:0] e_tag);
    @(posedge ref_clk);
    cpu_rxf_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rxf_rd <= 1'b0;
    #1;
    chk("read redirect", {14'h0000, txf_rd, rxf_rd}, {14'h0000, e_rd});
    chk("tag status", {14'h0000, rx_tag_status}, {14'h0000, e_tag});
  endtask : rpulse

  // one extra edge after 16 bits must not move the aligned pattern
  task ser(input int tb, input int m, input logic [7:0] cfg, input logic [15:0] v,
           input logic exp);
    wr(OFS_CFG, cfg);
    wr(OFS_TEST, 8'h00);
    wr(OFS_TEST, 8'(1 << tb));
    repeat (2) @(negedge ref_clk);
    chk("run started", {15'h0000, test_clk_run[m]}, 16'h0001);
    for (int i = 0; i < 17; i++) begin
      @(posedge ref_clk);
      test_sdi <= (i < 16) ? v[15 - i] : ~v[0];
      repeat (4) @(posedge ref_clk);
      receive_bit_clock <= 1'b1;
      repeat (4) @(posedge ref_clk);
      receive_bit_clock <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    #1;
    chk("test match", {15'h0000, test_match[m]}, {15'h0000, exp});
    chk("test clock run", {15'h0000, test_clk_run[m]}, 16'h0000);
    rd(OFS_STAT, rv);
    chk("test status", 16'(rv), 16'(exp) << m);
  endtask : ser

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    #(50 * 20000);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFS_TXCNT, rv);
    chk("count reset", 16'(rv), 16'(RST_BYTE));
    rd(OFS_TEST, rv);
    chk("test reset", 16'(rv), 16'(RST_BYTE));
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      chk("reg readback", 16'(rv), 16'(rows[i].e));
    end
    $display("test registers done");
    wr(OFS_TXCNT, 8'h02);
    for (int i = 0; i < 3; i++) push(1'b0, {8'hA0 + 8'(i), TAG_NONE});
    repeat (4) @(posedge ref_clk);
    pop(1'b0, {8'hA0, TAG_NONE});
    pop(1'b0, {8'hA1, TAG_EOP});
    pop(1'b0, {8'hA2, TAG_NONE});
    rd(OFS_TXCNT, rv);
    chk("count end", 16'(rv), 16'h0000);
    wr(OFS_CFG, 8'h01);
    wr(OFS_TXCNT, 8'h02);
    for (int i = 0; i < 4; i++) push(1'b0, {8'hB0 + 8'(i), TAG_NONE});
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) pop(1'b0, {8'hB0 + 8'(i), i[0] ? TAG_EOP : TAG_NONE});
    rd(OFS_TXCNT, rv);
    chk("count reload", 16'(rv), 16'h0002);
    wr(OFS_CFG, 8'h00);
    $display("test counter done");
    @(posedge ref_clk);
    txf_ready <= 1'b0;
    push(1'b0, {8'hC0, TAG_NONE});
    push(1'b0, {8'hC1, TAG_NONE});
    repeat (2) @(posedge ref_clk);
    #1;
    chk("full refuses", {15'h0000, cpu_txw_ready}, 16'h0000);
    @(posedge ref_clk);
    txf_ready <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pop(1'b0, {8'hC0, TAG_NONE});
    pop(1'b0, {8'hC1, TAG_EOP});
    chk("drained", {15'h0000, txf_valid}, 16'h0000);
    $display("test buffer done");
    wr(OFS_TEST, 8'h04);
    wr(OFS_TXCNT, 8'h01);
    push(1'b0, {8'hD5, TAG_NONE});
    repeat (4) @(posedge ref_clk);
    pop(1'b1, {8'hD5, TAG_EOP});
    chk("no tx word", 16'(txq.size()), 16'h0000);
    rpulse(2'b10, 2'b10);
    wr(OFS_TEST, 8'h00);
    rpulse(2'b01, 2'b01);
    $display("test fifo redirect done");
    wr(OFS_TEST, 8'h40);
    push(1'b1, {8'h77, TAG_EOP});
    push(1'b1, {8'h78, 2'b10});
    repeat (4) @(posedge ref_clk);
    pop(1'b0, {8'h77, TAG_EOP});
    pop(1'b1, {8'h77, TAG_EOP});
    pop(1'b0, {8'h78, 2'b10});
    pop(1'b1, {8'h78, 2'b10});
    wr(OFS_TEST, 8'h00);
    $display("test rx loop done");
    wr(OFS_CFG, 8'h06);
    wr(OFS_TEST, 8'h01);
    @(posedge ref_clk);
    line_rx_bit <= 1'b0;
    tx_serial_bit <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("tx loop bit", {15'h0000, rx_serial_in}, 16'h0001);
    chk("loop enables", {14'h0000, receiver_enable_bit, transmitter_enable_bit}, 16'h0003);
    wr(OFS_TEST, 8'h00);
    repeat (5) @(posedge ref_clk);
    #1;
    chk("line bit", {15'h0000, rx_serial_in}, 16'h0000);
    $display("test tx loop done");
    ser(TB_CRC, 0, 8'h00, CRC_REMAINDER, 1'b1);
    ser(TB_CRC, 0, 8'h08, CRC_REMAINDER, 1'b0);
    ser(TB_CRC, 0, 8'h58, CRC_REMAINDER ^ 16'h0020, 1'b1);
    ser(TB_ADDR, 1, 8'h00, ADDR_REF, 1'b1);
    ser(TB_ADDR, 1, 8'h00, ADDR_REF ^ 16'h8000, 1'b0);
    wr(OFS_TEST, 8'h00);
    $display("test serial done");
    wr(OFS_TXCNT, 8'h05);
    wr(OFS_TEST, 8'h84);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("soft set", {14'h0000, protocol_soft_reset, cpu_txw_ready}, 16'h0002);
    rd(OFS_TXCNT, rv);
    chk("soft count", 16'(rv), 16'h0000);
    rd(OFS_TEST, rv);
    chk("soft test reg", 16'(rv), 16'h0080);
    wr(OFS_TEST, 8'h00);
    wr(OFS_CFG, 8'h00);
    #1;
    chk("soft after one", {15'h0000, protocol_soft_reset}, 16'h0001);
    wr(OFS_TEST, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("soft after two", {15'h0000, protocol_soft_reset}, 16'h0000);
    wr(OFS_TEST, 8'h80);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("hard clears soft", {15'h0000, protocol_soft_reset}, 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("ready after reset", {14'h0000, cpu_txw_ready, rx_byte_ready}, 16'h0003);
    $display("test soft reset done");
    print_verdict();
  end
endmodule : hdtc_core_tb
`default_nettype wire
